// [design/audio_tx_pkg.sv]
package audio_tx_pkg;

   // channel word length selection
   typedef enum logic [1:0] {
      WORD16,
      WORD20,
      WORD24,
      WORD32
   } word_len_t;

   // multichannel layout
   typedef enum logic {
      CHAN_2P1,
      CHAN_5P1
   } chan_mode_t;

   typedef struct packed {
      logic [31:0] sample;
   } sample_word_t;

   localparam int SAMPLE_W      = 32;
   localparam int BUF_DEPTH     = 128;
   localparam int BUF_ADDR_W    = 7;
   localparam int FIFO_DEPTH    = 16;
   localparam int BITCNT_W      = 6;
   localparam logic [5:0] LEN16 = 6'h10;
   localparam logic [5:0] LEN20 = 6'h14;
   localparam logic [5:0] LEN24 = 6'h18;
   localparam logic [5:0] LEN32 = 6'h20;
   localparam logic [2:0] PAIRS_2P1 = 3'h2;
   localparam logic [2:0] PAIRS_5P1 = 3'h3;
   localparam real BITCLK_BENCH_NS = 160.0;
   localparam real SYS_PERIOD_NS   = 10.0;
   localparam int  BITCLK_CYCLES   = int'(BITCLK_BENCH_NS / SYS_PERIOD_NS);

   function automatic logic [5:0] wordBits(input word_len_t len);
      case (len)
         WORD16:  wordBits = LEN16;
         WORD20:  wordBits = LEN20;
         WORD24:  wordBits = LEN24;
         default: wordBits = LEN32;
      endcase
   endfunction

endpackage

// [design/sample_fifo.sv]
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   logic [AW:0]      next_wrPtr;
   logic [AW:0]      next_rdPtr;
   logic             next_inReady;
   logic             doWrite;
   logic             doRead;

   always_comb begin
      outValid   = wrPtr != rdPtr;
      outData    = mem[rdPtr[AW-1:0]];
      doWrite    = inValid && inReady;
      doRead     = outValid && outReady;
      next_wrPtr = doWrite ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = doRead ? rdPtr + 1'b1 : rdPtr;
      // ready kept in a flop so the fill side sees a registered signal
      next_inReady = (next_wrPtr - next_rdPtr) != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wrPtr   <= '0;
         rdPtr   <= '0;
         inReady <= 1'b1;
      end else begin
         wrPtr   <= next_wrPtr;
         rdPtr   <= next_rdPtr;
         inReady <= next_inReady;
      end
   end

   // storage has no reset; pointers alone define contents
   always_ff @(posedge clk_sys) begin
      if (doWrite) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule

// [design/audio_serial_slave_transmitter.sv]
`timescale 1ns/1ps
module audio_serial_slave_transmitter (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rstn,
   // configuration
   input  wire audio_tx_pkg::word_len_t        wordLen,
   input  wire audio_tx_pkg::chan_mode_t       chanMode,
   // sample stream in
   input  wire logic                           sampleValid,
   output logic                                sampleReady,
   input  wire audio_tx_pkg::sample_word_t     sampleData,
   // serial link
   input  wire logic                           audio_bit_clock_in,
   input  wire logic                           channel_select_in,
   output logic                                audio_serial_out,
   // status
   output logic                                underrun,
   output logic [2:0]                          slotIndex
);
   // input synchronisers, first stage read only by second
   logic [1:0] bclkSync;
   logic [1:0] wsSync;
   logic       bclkPrev;
   logic       fallEdge;
   logic       riseEdge;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         // idle high level, so release of reset shows no false edge
         bclkSync <= 2'h3;
         wsSync   <= 2'h3;
         bclkPrev <= 1'b1;
      end else begin
         bclkSync <= {bclkSync[0], audio_bit_clock_in};
         wsSync   <= {wsSync[0], channel_select_in};
         bclkPrev <= bclkSync[1];
      end
   end

   // edges found on sys clock; slave only, no timing is generated
   always_comb begin
      fallEdge = bclkPrev && !bclkSync[1];
      riseEdge = !bclkPrev && bclkSync[1];
   end

   // fifo feeds the sample memory
   logic         fifoValid;
   logic         fifoReady;
   logic [31:0]  fifoData;

   sample_fifo #(
      .WIDTH (audio_tx_pkg::SAMPLE_W),
      .DEPTH (audio_tx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .inData   (sampleData.sample),
      .outValid (fifoValid),
      .outReady (fifoReady),
      .outData  (fifoData)
   );

   // single-port ring memory: one access per cycle, read has priority
   logic [31:0] ram [audio_tx_pkg::BUF_DEPTH];
   logic [7:0]  wrIdx;
   logic [7:0]  rdIdx;
   logic [7:0]  next_wrIdx;
   logic [7:0]  next_rdIdx;
   logic [31:0] ramQ;
   logic        ramRead;
   logic        ramWrite;
   logic        bufEmpty;
   logic        bufFull;

   // slot state
   logic                  wsSeen;
   logic                  loadPending;
   logic                  loadPend2;
   logic [31:0]           shiftReg;
   logic [5:0]            bitsLeft;
   logic                  slotZero;
   logic                  serOut;
   logic                  underrunFlag;
   logic [2:0]            slot;
   logic                  next_wsSeen;
   logic                  next_loadPending;
   logic                  next_loadPend2;
   logic [31:0]           next_shiftReg;
   logic [5:0]            next_bitsLeft;
   logic                  next_slotZero;
   logic                  next_serOut;
   logic                  next_underrunFlag;
   logic [2:0]            next_slot;
   logic [2:0]            lastSlot;
   logic [5:0]            lenBits;
   logic                  wsChange;

   always_comb begin
      bufEmpty = wrIdx == rdIdx;
      bufFull  = (wrIdx - rdIdx) == 8'(audio_tx_pkg::BUF_DEPTH);
      lenBits  = audio_tx_pkg::wordBits(wordLen);
      // 2.1 uses 2 stereo pairs, 5.1 uses 3 pairs in rotation
      lastSlot = (chanMode == audio_tx_pkg::CHAN_5P1) ?
                 (audio_tx_pkg::PAIRS_5P1 << 1) - 3'h1 :
                 (audio_tx_pkg::PAIRS_2P1 << 1) - 3'h1;
      wsChange = riseEdge && (wsSync[1] != wsSeen);
      ramRead  = wsChange && !bufEmpty;
      ramWrite = fifoValid && !bufFull && !ramRead;
      fifoReady = ramWrite;
      next_wrIdx = ramWrite ? wrIdx + 8'h01 : wrIdx;
      next_rdIdx = ramRead ? rdIdx + 8'h01 : rdIdx;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wrIdx <= '0;
         rdIdx <= '0;
      end else begin
         wrIdx <= next_wrIdx;
         rdIdx <= next_rdIdx;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ramRead) begin
         ramQ <= ram[rdIdx[6:0]];
      end else if (ramWrite) begin
         ram[wrIdx[6:0]] <= fifoData;
      end
   end

   // word select sampled on rising edge; the slot starts on the next falling
   // edge, which is one bit clock after the select transition
   always_comb begin
      next_wsSeen       = wsSeen;
      next_loadPending  = loadPending;
      next_loadPend2    = 1'b0;
      next_shiftReg     = shiftReg;
      next_bitsLeft     = bitsLeft;
      next_slotZero     = slotZero;
      next_serOut       = serOut;
      next_underrunFlag = underrunFlag;
      next_slot         = slot;
      if (wsChange) begin
         next_wsSeen      = wsSync[1];
         next_loadPending = 1'b1;
         next_slotZero    = bufEmpty;
         next_loadPend2   = ramRead;
         if (!wsSync[1]) begin
            // left opens the next pair; first left after reset or last pair gives zero
            next_slot = (slot[0] && slot < lastSlot) ? slot + 3'h1 : 3'h0;
         end else begin
            next_slot = {slot[2:1], 1'b1};
         end
         if (bufEmpty) begin
            next_underrunFlag = 1'b1;
         end
      end
      if (loadPend2) begin
         next_shiftReg = ramQ;
      end else if (fallEdge) begin
         if (loadPending) begin
            next_loadPending = 1'b0;
            next_bitsLeft    = lenBits - 6'h01;
            next_serOut      = slotZero ? 1'b0 : shiftReg[31];
            next_shiftReg    = {shiftReg[30:0], 1'b0};
         end else if (bitsLeft != 6'h00) begin
            next_bitsLeft = bitsLeft - 6'h01;
            next_serOut   = slotZero ? 1'b0 : shiftReg[31];
            next_shiftReg = {shiftReg[30:0], 1'b0};
         end else begin
            next_serOut = 1'b0;
         end
      end
      if (wsChange && !bufEmpty) begin
         next_underrunFlag = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wsSeen       <= 1'b1;
         loadPending  <= 1'b0;
         loadPend2    <= 1'b0;
         shiftReg     <= '0;
         bitsLeft     <= '0;
         slotZero     <= 1'b1;
         serOut       <= 1'b0;
         underrunFlag <= 1'b0;
         slot         <= 3'h0;
      end else begin
         wsSeen       <= next_wsSeen;
         loadPending  <= next_loadPending;
         loadPend2    <= next_loadPend2;
         shiftReg     <= next_shiftReg;
         bitsLeft     <= next_bitsLeft;
         slotZero     <= next_slotZero;
         serOut       <= next_serOut;
         underrunFlag <= next_underrunFlag;
         slot         <= next_slot;
      end
   end

   always_comb begin
      audio_serial_out = serOut;
      underrun         = underrunFlag;
      slotIndex        = slot;
   end
endmodule

// [verification/audio_master_model.sv]
`timescale 1ns/1ps
module audio_master_model (
   // control
   input  wire logic       go,
   input  wire logic [7:0] nFrames,
   input  wire logic [7:0] slotBits,
   output logic            busy,
   // link
   output logic            bitClk,
   output logic            wordSel,
   input  wire logic       serialIn,
   // captured words
   output logic            rxStrobe,
   output logic [31:0]     rxWord
);
   logic [31:0] sh;
   int          c, t;
   // clock and select park high between bursts
   initial begin
      {busy, bitClk, wordSel, rxStrobe} = 4'h6;
      rxWord = '0;
      sh = '0;
      forever begin
         @(posedge go);
         busy = 1'b1;
         #37;
         t = 2 * nFrames * slotBits;
         // one extra bit at the end flushes the last lsb
         for (c = 0; c <= t; c++) begin
            #80 bitClk = 1'b0;
            if (c < t && c % slotBits == 0) wordSel = 1'((c / slotBits) % 2);
            #80 bitClk = 1'b1;
            sh = {sh[30:0], serialIn};
            if (c > 0 && c % slotBits == 0) begin
               rxWord = sh << (32 - slotBits);
               rxStrobe = ~rxStrobe;
            end
         end
         busy = 1'b0;
      end
   end
endmodule

// [verification/audio_tx_properties.sv]
`timescale 1ns/1ps
module audio_tx_properties (
   // clock and reset
   input wire logic                     clk_sys,
   input wire logic                     rstn,
   // watched ports
   input wire audio_tx_pkg::chan_mode_t chanMode,
   input wire logic                     sampleReady,
   input wire logic                     audio_bit_clock_in,
   input wire logic                     channel_select_in,
   input wire logic                     audio_serial_out,
   input wire logic                     underrun,
   input wire logic [2:0]               slotIndex
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic       bq, wq;
   logic [4:0] fAge, wAge, uAge, next_fAge, next_wAge, next_uAge;
   // ages saturate so a long idle never wraps into a window
   always_comb begin
      next_fAge = (bq && !audio_bit_clock_in) ? 5'h00 : fAge + {4'h0, ~&fAge};
      next_wAge = (wq != channel_select_in) ? 5'h00 : wAge + {4'h0, ~&wAge};
      next_uAge = underrun ? uAge + {4'h0, ~&uAge} : 5'h00;
   end
   always_ff @(posedge clk_sys) begin
      bq <= audio_bit_clock_in;
      wq <= channel_select_in;
      fAge <= rstn ? next_fAge : 5'h1F;
      wAge <= rstn ? next_wAge : 5'h1F;
      uAge <= rstn ? next_uAge : 5'h00;
   end
   a_reset_quiet: assert property ($rose(rstn) |-> !audio_serial_out && slotIndex == 3'h0)
      else $error("outputs not idle after reset");
   a_ready_reset: assert property ($rose(rstn) |-> sampleReady)
      else $error("buffer not ready after reset");
   a_slot_range: assert property ($changed(slotIndex) |->
      slotIndex < ((chanMode == audio_tx_pkg::CHAN_5P1) ? 3'h6 : 3'h4))
      else $error("slot index out of range");
   a_slot_step: assert property ($changed(slotIndex) |->
      slotIndex == 3'h0 || slotIndex == $past(slotIndex) + 3'h1)
      else $error("slot index skipped");
   a_slot_on_select: assert property ($changed(slotIndex) |-> wAge < 5'h18)
      else $error("slot moved without select change");
   a_launch_fall: assert property ($changed(audio_serial_out) |-> fAge < 5'h08)
      else $error("data changed away from falling edge");
   a_underrun_zero: assert property (uAge > 5'h0C |-> !audio_serial_out)
      else $error("data sent during underrun");
   a_underrun_slot: assert property ($rose(underrun) |-> wAge < 5'h18)
      else $error("underrun away from slot start");
   c_underrun: cover property ($rose(underrun));
   c_six_slots: cover property ($changed(slotIndex) && slotIndex == 3'h5);
   c_full: cover property ($fell(sampleReady));
endmodule
bind audio_serial_slave_transmitter audio_tx_properties u_audio_tx_properties (
   .clk_sys(clk_sys), .rstn(rstn), .chanMode(chanMode), .sampleReady(sampleReady),
   .audio_bit_clock_in(audio_bit_clock_in), .channel_select_in(channel_select_in),
   .audio_serial_out(audio_serial_out), .underrun(underrun), .slotIndex(slotIndex)
);

// [verification/audio_serial_slave_transmitter_bench.sv]
`timescale 1ns/1ps
module audio_serial_slave_transmitter_bench;
   logic                       clk_sys, rstn, sampleValid, sampleReady, go, busy, ok;
   logic                       bitClk, wordSel, serialOut, underrun, rxStrobe;
   logic [2:0]                 slotIndex;
   logic [7:0]                 nFrames, slotBits;
   logic [31:0]                rxWord;
   logic [31:0]                expq[$];
   audio_tx_pkg::word_len_t    wordLen;
   audio_tx_pkg::chan_mode_t   chanMode;
   audio_tx_pkg::sample_word_t sampleData;
   int                         err_count, total_checks, i, j, rnd;
   int                         lens[4] = '{16, 20, 24, 32};
   audio_serial_slave_transmitter u_audio_serial_slave_transmitter (
      .clk_sys(clk_sys), .rstn(rstn), .wordLen(wordLen), .chanMode(chanMode),
      .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleData(sampleData),
      .audio_bit_clock_in(bitClk), .channel_select_in(wordSel),
      .audio_serial_out(serialOut), .underrun(underrun), .slotIndex(slotIndex)
   );
   audio_master_model u_audio_master_model (
      .go(go), .nFrames(nFrames), .slotBits(slotBits), .busy(busy), .bitClk(bitClk),
      .wordSel(wordSel), .serialIn(serialOut), .rxStrobe(rxStrobe), .rxWord(rxWord)
   );
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // valid stays up between pushes so it is never driven twice in one step
   task automatic push(input logic [31:0] v, input logic [31:0] m);
      int k;
      sampleValid <= 1'b1;
      sampleData <= v;
      ok = 1'b0;
      for (k = 0; k < 4 && !ok; k++) begin
         @(negedge clk_sys);
         ok = sampleReady === 1'b1;
         @(posedge clk_sys);
      end
      if (ok) expq.push_back(v & m);
   endtask
   task automatic run(input logic [7:0] n, input logic [7:0] sb);
      int k;
      sampleValid <= 1'b0;
      nFrames <= n;
      slotBits <= sb;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      for (k = 0; k < 45000 && busy !== 1'b0; k++) @(posedge clk_sys);
      if (k == 45000) begin
         err_count++;
         print_verdict();
      end
      repeat (4) @(posedge clk_sys);
      check(32'(expq.size()), 32'h0);
   endtask
   always @(rxStrobe) begin
      if ($time > 0) check(rxWord, (expq.size() > 0) ? expq.pop_front() : ~rxWord);
   end
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      {rstn, sampleValid, go} = 3'h0;
      sampleData = '0;
      {nFrames, slotBits} = 16'h0;
      wordLen = audio_tx_pkg::WORD32;
      chanMode = audio_tx_pkg::CHAN_2P1;
      {err_count, total_checks} = 64'h0;
      rnd = $urandom(32'hBB37C26D);
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      // every length in both layouts, tails after short words must be zero
      for (i = 0; i < 8; i++) begin
         wordLen <= audio_tx_pkg::word_len_t'(i % 4);
         chanMode <= audio_tx_pkg::chan_mode_t'(i / 4);
         for (j = 0; j < 6; j++) push($urandom, ~(32'hFFFFFFFF >> lens[i % 4]));
         run(8'd3, 8'd32);
      end
      wordLen <= audio_tx_pkg::WORD16;
      chanMode <= audio_tx_pkg::CHAN_2P1;
      j = 0;
      ok = 1'b1;
      while (ok && j < 200) begin
         push($urandom, 32'hFFFF0000);
         j += int'(ok);
      end
      check(32'(j), 32'(audio_tx_pkg::FIFO_DEPTH + audio_tx_pkg::BUF_DEPTH));
      run(8'd72, 8'd16);
      expq.push_back(32'h0);
      expq.push_back(32'h0);
      run(8'd1, 8'd16);
      check({31'h0, underrun}, 32'h1);
      push(32'h8001_2345, 32'hFFFF0000);
      push(32'h7FFE_0000, 32'hFFFF0000);
      run(8'd1, 8'd16);
      check({31'h0, underrun}, 32'h0);
      print_verdict();
   end
endmodule
